//--- core/uhep_pkg.sv
`default_nettype none

package uhep_pkg;

	// APB register map (byte addresses, word aligned)
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] OFS_EP_CFG = 12'h000;
	localparam logic [11:0] OFS_RX_CTRL = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;

	// Endpoint configuration word layout
	localparam int unsigned INTERV_LSB = 24;
	localparam int unsigned SPEED_LSB = 22;
	localparam int unsigned PROTO_LSB = 20;
	localparam int unsigned TEP_LSB = 16;
	localparam int unsigned RX_BYTE_COUNT_W = 14;

	// Receive control word layout
	localparam int unsigned AUTO_CLEAR_READY_BIT = 31;
	localparam int unsigned READY_BIT = 16;
	localparam int unsigned MAXP_W = 11;

	// Status word layout
	localparam int unsigned ST_NAKTO_BIT = 0;
	localparam int unsigned ST_BADCFG_BIT = 1;
	localparam int unsigned ST_OVF_BIT = 2;

	// Reset values
	localparam logic [7:0] INTERV_RST = 8'h00;
	localparam logic [1:0] SPEED_RST = 2'h0;
	localparam logic [1:0] PROTO_RST = 2'h0;
	localparam logic [3:0] TEP_RST = 4'h0;
	localparam logic [10:0] MAXP_RST = 11'h000;

	// Speed codes
	localparam logic [1:0] SPD_LOW = 2'h3;
	localparam logic [1:0] SPD_FULL = 2'h2;
	localparam logic [1:0] SPD_HIGH = 2'h1;

	// Transfer type codes
	localparam logic [1:0] PROTO_INTR = 2'h3;
	localparam logic [1:0] PROTO_BULK = 2'h2;
	localparam logic [1:0] PROTO_ISO = 2'h1;
	localparam logic [1:0] PROTO_CTRL = 2'h0;

	// Interval field limits
	localparam logic [7:0] M_MIN = 8'h01;
	localparam logic [7:0] M_MIN_BULK = 8'h02;
	localparam logic [7:0] M_MAX_POW = 8'h10;

	// Frame counter width, holds 2^15
	localparam int unsigned CNT_W = 16;

	// Receive FIFO geometry
	localparam int unsigned RX_DEPTH = 2048;
	localparam int unsigned RX_PTR_W = 11;
	localparam logic [13:0] RX_FULL_CNT = 14'h0800;

	// Bulk NAK run tracker
	typedef enum logic {
		NAK_IDLE,
		NAK_RUN
	} uhep_nak_t;

endpackage : uhep_pkg

`default_nettype wire

//--- core/uhep_interval.sv
`default_nettype none

module uhep_interval (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, low
	input wire logic frame_tick, // Start of frame or microframe
	input wire logic [7:0] interval, // Poll interval or NAK limit
	input wire logic [1:0] speed, // Endpoint speed code
	input wire logic [1:0] protocol, // Transfer type code
	input wire logic resp_valid, // Endpoint answered a token
	input wire logic resp_nak, // That answer was a NAK
	output logic poll_req, // Pulse: poll the endpoint now
	output logic nak_timeout, // Pulse: NAK run hit its limit
	output logic cfg_invalid // Interval or speed code invalid for the transfer type
);

	typedef uhep_pkg::uhep_nak_t uhep_nak_state_t;

	typedef struct packed {
		logic [uhep_pkg::CNT_W-1:0] cnt;
		uhep_nak_state_t run;
		logic poll;
		logic tout;
	} uhep_ivl_t;

	uhep_ivl_t s_q;
	uhep_ivl_t s_d;
	logic [uhep_pkg::CNT_W-1:0] period;
	logic periodic;
	logic bulk_on;
	logic in_pow;
	logic [uhep_pkg::CNT_W-1:0] pow_val;
	logic [uhep_pkg::CNT_W-1:0] cnt_inc;

	// Decode interval into a frame count per transfer type
	always_comb begin
		in_pow = (interval >= uhep_pkg::M_MIN) && (interval <= uhep_pkg::M_MAX_POW);
		pow_val = '0;
		if (in_pow) begin
			pow_val = uhep_pkg::CNT_W'(1) << interval[3:0] - 4'h1;
		end
		period = '0;
		periodic = 1'b0;
		bulk_on = 1'b0;
		cfg_invalid = 1'b0;
		case (protocol)
			uhep_pkg::PROTO_INTR: begin
				if (speed == uhep_pkg::SPD_HIGH) begin
					periodic = in_pow;
					period = pow_val;
					cfg_invalid = !in_pow;
				end else if (speed == uhep_pkg::SPD_LOW || speed == uhep_pkg::SPD_FULL) begin
					periodic = interval >= uhep_pkg::M_MIN;
					period = {8'h00, interval};
					cfg_invalid = interval < uhep_pkg::M_MIN;
				end else begin
					cfg_invalid = 1'b1;
				end
			end
			uhep_pkg::PROTO_ISO: begin
				// Only full and high speed poll; low and reserved codes stay idle
				periodic = in_pow && (speed == uhep_pkg::SPD_FULL || speed == uhep_pkg::SPD_HIGH);
				period = pow_val;
				cfg_invalid = !periodic;
			end
			uhep_pkg::PROTO_BULK: begin
				// Values 0 and 1 switch the time-out off
				bulk_on = interval >= uhep_pkg::M_MIN_BULK && in_pow;
				period = pow_val;
				cfg_invalid = interval > uhep_pkg::M_MAX_POW;
			end
			default: begin
				cfg_invalid = 1'b0;
			end
		endcase
	end

	assign cnt_inc = s_q.cnt + uhep_pkg::CNT_W'(1);

	// Poll scheduler and NAK run counter share one frame counter
	always_comb begin
		s_d = s_q;
		s_d.poll = 1'b0;
		s_d.tout = 1'b0;
		if (periodic) begin
			s_d.run = uhep_pkg::NAK_IDLE;
			if (frame_tick) begin
				if (cnt_inc >= period) begin
					s_d.cnt = '0;
					s_d.poll = 1'b1;
				end else begin
					s_d.cnt = cnt_inc;
				end
			end
		end else if (bulk_on) begin
			if (resp_valid && !resp_nak) begin
				s_d.run = uhep_pkg::NAK_IDLE;
				s_d.cnt = '0;
			end else begin
				if (resp_valid && s_q.run == uhep_pkg::NAK_IDLE) begin
					s_d.run = uhep_pkg::NAK_RUN;
					s_d.cnt = '0;
				end
				if (frame_tick && s_q.run == uhep_pkg::NAK_RUN) begin
					if (cnt_inc >= period) begin
						s_d.tout = 1'b1;
						s_d.cnt = '0;
						s_d.run = uhep_pkg::NAK_IDLE;
					end else begin
						s_d.cnt = cnt_inc;
					end
				end
			end
		end else begin
			s_d.cnt = '0;
			s_d.run = uhep_pkg::NAK_IDLE;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign poll_req = s_q.poll;
	assign nak_timeout = s_q.tout;

endmodule // uhep_interval

`default_nettype wire

//--- core/uhep_top.sv
`default_nettype none

module uhep_top (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte lanes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic frame_tick, // Frame or microframe start
	input wire logic resp_valid, // Endpoint handshake seen
	input wire logic resp_nak, // Handshake was NAK
	input wire logic rx_push_valid, // Received byte offered
	input wire logic [7:0] rx_push_data, // Received byte
	output logic rx_push_ready, // FIFO can take a byte
	input wire logic rx_pkt_end, // Last byte of a packet stored
	input wire logic rx_pop_req, // Unload one byte
	output logic rx_pop_avail, // FIFO holds data
	output logic [7:0] rx_pop_data, // Unloaded byte
	output logic rx_pop_done, // Pulse: rx_pop_data is new
	output logic rx_ready_flag, // Packet ready flag
	output logic poll_req, // Pulse: poll endpoint now
	output logic nak_timeout, // Pulse: bulk NAK time-out
	output logic [1:0] ep_speed, // Operating speed code
	output logic [1:0] ep_protocol, // Transfer type code
	output logic [3:0] ep_target // Remote endpoint number
);

	typedef struct packed {
		logic [7:0] interval;
		logic [1:0] speed;
		logic [1:0] proto;
		logic [3:0] target_endpoint_number;
		logic auto_clear_ready;
		logic [uhep_pkg::MAXP_W-1:0] maxp;
		logic ready;
		logic [uhep_pkg::RX_BYTE_COUNT_W-1:0] count;
		logic [uhep_pkg::RX_PTR_W-1:0] wr_ptr;
		logic [uhep_pkg::RX_PTR_W-1:0] rd_ptr;
		logic [uhep_pkg::MAXP_W-1:0] unload;
		logic st_nakto;
		logic st_ovf;
		logic [31:0] rdata;
		logic [7:0] pop_data;
		logic pop_done;
	} uhep_state_t;

	uhep_state_t s_q;
	uhep_state_t s_d;
	logic [7:0] rx_mem [uhep_pkg::RX_DEPTH];
	logic sel_cfg;
	logic sel_ctrl;
	logic sel_stat;
	logic mapped;
	logic setup_ph;
	logic wr_en;
	logic push_ok;
	logic pop_ok;
	logic cfg_invalid;
	logic timeout_pulse;
	logic [31:0] cfg_word;
	logic [31:0] ctrl_word;
	logic [31:0] stat_word;
	logic [31:0] rd_mux;
	logic [31:0] cfg_new;
	logic [31:0] ctrl_new;
	logic [uhep_pkg::MAXP_W-1:0] unload_inc;

	// Byte-lane merge of a write into the old word
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Address decode on word index
	assign sel_cfg = paddr[11:2] == uhep_pkg::OFS_EP_CFG[11:2];
	assign sel_ctrl = paddr[11:2] == uhep_pkg::OFS_RX_CTRL[11:2];
	assign sel_stat = paddr[11:2] == uhep_pkg::OFS_STATUS[11:2];
	assign mapped = sel_cfg | sel_ctrl | sel_stat;
	assign setup_ph = psel & ~penable;
	assign wr_en = psel & penable & pwrite & mapped;

	// Zero wait states; read data was captured in setup
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = s_q.rdata;

	// Register images as software sees them
	always_comb begin
		cfg_word = '0;
		cfg_word[uhep_pkg::INTERV_LSB +: 8] = s_q.interval;
		cfg_word[uhep_pkg::SPEED_LSB +: 2] = s_q.speed;
		cfg_word[uhep_pkg::PROTO_LSB +: 2] = s_q.proto;
		cfg_word[uhep_pkg::TEP_LSB +: 4] = s_q.target_endpoint_number;
		cfg_word[uhep_pkg::RX_BYTE_COUNT_W-1:0] = s_q.count;
		ctrl_word = '0;
		ctrl_word[uhep_pkg::AUTO_CLEAR_READY_BIT] = s_q.auto_clear_ready;
		ctrl_word[uhep_pkg::READY_BIT] = s_q.ready;
		ctrl_word[uhep_pkg::MAXP_W-1:0] = s_q.maxp;
		stat_word = '0;
		stat_word[uhep_pkg::ST_NAKTO_BIT] = s_q.st_nakto;
		stat_word[uhep_pkg::ST_BADCFG_BIT] = cfg_invalid;
		stat_word[uhep_pkg::ST_OVF_BIT] = s_q.st_ovf;
		if (sel_cfg) begin
			rd_mux = cfg_word;
		end else if (sel_ctrl) begin
			rd_mux = ctrl_word;
		end else if (sel_stat) begin
			rd_mux = stat_word;
		end else begin
			rd_mux = '0;
		end
		cfg_new = lane_merge(cfg_word, pwdata, pstrb);
		ctrl_new = lane_merge(ctrl_word, pwdata, pstrb);
	end

	// FIFO handshakes
	assign push_ok = rx_push_valid & (s_q.count != uhep_pkg::RX_FULL_CNT);
	assign pop_ok = rx_pop_req & (s_q.count != '0);
	assign rx_push_ready = s_q.count != uhep_pkg::RX_FULL_CNT;
	assign rx_pop_avail = s_q.count != '0;
	assign unload_inc = s_q.unload + uhep_pkg::MAXP_W'(1);

	// Next-state logic for registers, FIFO pointers and flags
	always_comb begin
		s_d = s_q;
		s_d.pop_done = 1'b0;

		// Read data is snapshot in the setup phase
		if (setup_ph) begin
			s_d.rdata = pwrite ? '0 : rd_mux;
		end

		// Configuration writes; bits 15-0 of this word are not stored
		if (wr_en && sel_cfg) begin
			s_d.interval = cfg_new[uhep_pkg::INTERV_LSB +: 8];
			s_d.speed = cfg_new[uhep_pkg::SPEED_LSB +: 2];
			s_d.proto = cfg_new[uhep_pkg::PROTO_LSB +: 2];
			s_d.target_endpoint_number = cfg_new[uhep_pkg::TEP_LSB +: 4];
		end

		// Receive control writes
		if (wr_en && sel_ctrl) begin
			s_d.auto_clear_ready = ctrl_new[uhep_pkg::AUTO_CLEAR_READY_BIT];
			s_d.maxp = ctrl_new[uhep_pkg::MAXP_W-1:0];
			// Software may only clear the ready flag
			if (!ctrl_new[uhep_pkg::READY_BIT]) begin
				s_d.ready = 1'b0;
				s_d.unload = '0;
			end
		end

		// Sticky status, write one to clear
		if (wr_en && sel_stat && pstrb[0]) begin
			if (pwdata[uhep_pkg::ST_NAKTO_BIT]) begin
				s_d.st_nakto = 1'b0;
			end
			if (pwdata[uhep_pkg::ST_OVF_BIT]) begin
				s_d.st_ovf = 1'b0;
			end
		end

		// Byte store
		if (push_ok) begin
			s_d.wr_ptr = s_q.wr_ptr + uhep_pkg::RX_PTR_W'(1);
		end

		// Byte unload and auto-clear on a full packet
		if (pop_ok) begin
			s_d.rd_ptr = s_q.rd_ptr + uhep_pkg::RX_PTR_W'(1);
			s_d.pop_data = rx_mem[s_q.rd_ptr];
			s_d.pop_done = 1'b1;
			if (s_q.ready) begin
				s_d.unload = unload_inc;
				if (s_q.auto_clear_ready && s_q.maxp != '0 && unload_inc == s_q.maxp) begin
					s_d.ready = 1'b0;
					s_d.unload = '0;
				end
			end
		end

		// Live byte count follows every store and unload
		case ({push_ok, pop_ok})
			2'h2: s_d.count = s_q.count + uhep_pkg::RX_BYTE_COUNT_W'(1);
			2'h1: s_d.count = s_q.count - uhep_pkg::RX_BYTE_COUNT_W'(1);
			default: s_d.count = s_q.count;
		endcase

		// Hardware sets win over any clear in the same cycle
		if (rx_pkt_end) begin
			s_d.ready = 1'b1;
		end
		if (rx_push_valid && !push_ok) begin
			s_d.st_ovf = 1'b1;
		end
		if (timeout_pulse) begin
			s_d.st_nakto = 1'b1;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.interval <= uhep_pkg::INTERV_RST;
			s_q.speed <= uhep_pkg::SPEED_RST;
			s_q.proto <= uhep_pkg::PROTO_RST;
			s_q.target_endpoint_number <= uhep_pkg::TEP_RST;
			s_q.maxp <= uhep_pkg::MAXP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// FIFO storage, no reset needed
	always_ff @(posedge pclk) begin
		if (push_ok) begin
			rx_mem[s_q.wr_ptr] <= rx_push_data;
		end
	end

	// Polling and NAK time-out scheduler
	uhep_interval u_interval (
		.pclk(pclk),
		.presetn(presetn),
		.frame_tick(frame_tick),
		.interval(s_q.interval),
		.speed(s_q.speed),
		.protocol(s_q.proto),
		.resp_valid(resp_valid),
		.resp_nak(resp_nak),
		.poll_req(poll_req),
		.nak_timeout(timeout_pulse),
		.cfg_invalid(cfg_invalid)
	);

	// Outputs to the transaction engine
	assign nak_timeout = timeout_pulse;
	assign rx_pop_data = s_q.pop_data;
	assign rx_pop_done = s_q.pop_done;
	assign rx_ready_flag = s_q.ready;
	assign ep_speed = s_q.speed;
	assign ep_protocol = s_q.proto;
	assign ep_target = s_q.target_endpoint_number;

endmodule // uhep_top

`default_nettype wire

//--- test/uhep_dev.sv
`default_nettype none

module uhep_dev (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, low
	input wire logic poll_req, // Host poll
	input wire logic ask, // Extra token
	input wire logic nak_mode, // Answer NAK
	input wire logic [7:0] send_n, // Packet length
	input wire logic send_go, // Start packet
	input wire logic rx_push_ready, // FIFO room
	output logic resp_valid, // Handshake
	output logic resp_nak, // Handshake is NAK
	output logic rx_push_valid, // Byte offered
	output logic [7:0] rx_push_data, // Byte
	output logic rx_pkt_end // Packet stored
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] left_q, idx_q;
	// Byte only while a packet lasts, else inverted
	assign rx_push_valid = left_q != 8'h00;
	assign rx_push_data = rx_push_valid ? idx_q : ~idx_q;
	// Answer a token next cycle, push bytes in order
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q <= 8'h00;
			idx_q <= 8'h00;
			resp_valid <= 1'b0;
			resp_nak <= 1'b0;
			rx_pkt_end <= 1'b0;
		end else begin
			resp_valid <= poll_req | ask;
			resp_nak <= (poll_req | ask) ? nak_mode : ~resp_nak;
			rx_pkt_end <= rx_push_valid && rx_push_ready && left_q == 8'h01;
			if (send_go) begin
				left_q <= send_n;
				idx_q <= 8'h10;
			end else if (rx_push_valid && rx_push_ready) begin
				left_q <= left_q - 8'h01;
				idx_q <= idx_q + 8'h01;
			end
		end
	end
endmodule // uhep_dev

`default_nettype wire

//--- test/uhep_assertions.sv
`default_nettype none

module uhep_chk (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, low
	input wire logic frame_tick, // Frame start
	input wire logic resp_valid, // Handshake
	input wire logic resp_nak, // Is NAK
	input wire logic rx_pop_req, // Pop
	input wire logic rx_pop_avail, // Data held
	input wire logic rx_pop_done, // Pop answer
	input wire logic poll_req, // Poll
	input wire logic nak_timeout, // Time-out
	input wire logic [1:0] ep_speed, // Speed
	input wire logic [1:0] ep_protocol // Type
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Polls and time-outs follow a frame start
	a_poll_on_tick: assert property (poll_req |-> $past(frame_tick))
		else $error("poll without frame start");
	a_to_on_tick: assert property (nak_timeout |-> $past(frame_tick))
		else $error("time-out without frame start");
	a_to_once: assert property (nak_timeout |=> !nak_timeout)
		else $error("time-out pulse too long");
	// Reserved speed and control type never poll
	a_rsvd_no_poll: assert property (ep_speed == 2'h0 && $past(ep_speed) == 2'h0 |-> !poll_req)
		else $error("poll at reserved speed");
	a_ctrl_no_poll: assert property (ep_protocol == 2'h0 && $past(ep_protocol) == 2'h0 |-> !poll_req)
		else $error("poll on control endpoint");
	// A non-NAK answer breaks the run
	a_ack_restart: assert property (resp_valid && !resp_nak && !frame_tick |=> !nak_timeout)
		else $error("time-out right after a non-NAK answer");
	// Each taken pop answers next cycle
	a_pop_answer: assert property (rx_pop_req && rx_pop_avail |=> rx_pop_done)
		else $error("pop not answered");
	a_pop_spurious: assert property (!(rx_pop_req && rx_pop_avail) |=> !rx_pop_done)
		else $error("pop answer without pop");
	c_poll: cover property (poll_req);
	c_timeout: cover property (nak_timeout);
	c_pop: cover property (rx_pop_done);
endmodule // uhep_chk

bind uhep_top uhep_chk chk_u (.pclk, .presetn, .frame_tick, .resp_valid, .resp_nak,
	.rx_pop_req, .rx_pop_avail, .rx_pop_done, .poll_req, .nak_timeout, .ep_speed,
	.ep_protocol);

`default_nettype wire

//--- test/tb_top.sv
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] CFG_A = uhep_pkg::OFS_EP_CFG;
	localparam logic [11:0] RXC_A = uhep_pkg::OFS_RX_CTRL;
	localparam logic [11:0] ST_A = uhep_pkg::OFS_STATUS;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, r, v;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, frame_tick = 1'b0, resp_valid, resp_nak, e;
	logic rx_push_valid, rx_push_ready, rx_pkt_end, rx_pop_req = 1'b0;
	logic rx_pop_avail, rx_pop_done, rx_ready_flag, poll_req, nak_timeout;
	logic [7:0] rx_push_data, rx_pop_data, send_n = 8'h00;
	logic [1:0] ep_speed, ep_protocol;
	logic [3:0] ep_target;
	logic ask = 1'b0, nak_mode = 1'b0, send_go = 1'b0;
	logic [7:0] pm [6] = '{8'h03, 8'h02, 8'hff, 8'h03, 8'h02, 8'h03};
	logic [1:0] ps [6] = '{2'h2, 2'h3, 2'h3, 2'h1, 2'h2, 2'h1};
	logic [1:0] pp [6] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h1};
	int pe [6] = '{3, 2, 255, 4, 2, 4};
	int bad_count = 0, checked = 0, polls = 0, tos = 0, cyc = 0;
	uhep_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .frame_tick, .resp_valid, .resp_nak, .rx_push_valid,
		.rx_push_data, .rx_push_ready, .rx_pkt_end, .rx_pop_req, .rx_pop_avail,
		.rx_pop_data, .rx_pop_done, .rx_ready_flag, .poll_req, .nak_timeout, .ep_speed,
		.ep_protocol, .ep_target);
	uhep_dev dev_u (.pclk, .presetn, .poll_req, .ask, .nak_mode, .send_n, .send_go,
		.rx_push_ready, .resp_valid, .resp_nak, .rx_push_valid, .rx_push_data, .rx_pkt_end);
	always #12.5 pclk = ~pclk;
	// Pulse counters and run limit
	always @(posedge pclk) begin
		cyc++;
		if (poll_req === 1'b1) polls++;
		if (nak_timeout === 1'b1) tos++;
		if (cyc == 40000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask
	// One APB transfer, then an idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, x, input string n);
		apb(1'b0, a, 32'h00000000);
		chk(n, r & m, x);
	endtask
	task automatic cfg(input logic [7:0] m, input logic [1:0] s, p);
		apb(1'b1, CFG_A, {m, s, p, 20'h00000});
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			frame_tick <= 1'b1;
			@(posedge pclk);
			frame_tick <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask
	// Second gap between polls, in frames
	task automatic period(input int x);
		int c;
		for (int k = 0; k < 2; k++) begin
			polls = 0;
			c = 0;
			while (polls == 0 && c < 300) begin
				tick(1);
				c++;
			end
		end
		chk("poll period", c, x);
	endtask
	task automatic hs(input logic nk);
		nak_mode <= nk;
		ask <= 1'b1;
		@(posedge pclk);
		ask <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic pop(input logic [7:0] x);
		rx_pop_req <= 1'b1;
		@(posedge pclk);
		rx_pop_req <= 1'b0;
		@(posedge pclk);
		chk("pop data", {24'h0, rx_pop_data}, {24'h0, x});
	endtask
	task automatic send(input logic [7:0] n);
		int c;
		send_n <= n;
		send_go <= 1'b1;
		@(posedge pclk);
		send_go <= 1'b0;
		for (c = 0; c < 100 && rx_ready_flag !== 1'b1; c++) @(posedge pclk);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CFG_A, 32'hffffffff, 32'h0, "cfg reset");
		chk("fifo flags", {30'h0, rx_push_ready, rx_pop_avail}, 32'h2);
		// Every speed and type code, unused bits written high
		for (int i = 0; i < 4; i++) begin
			v = {8'h00, 2'(i), 2'(3 - i), 4'(5 * i), 16'h0000};
			apb(1'b1, CFG_A, v | 32'h0000ffff);
			chk("speed", {30'h0, ep_speed}, 32'(i));
			chk("type", {30'h0, ep_protocol}, 32'(3 - i));
			chk("target", {28'h0, ep_target}, 32'(5 * i));
			rd(CFG_A, 32'hffffffff, v, "cfg word");
		end
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped", {e, r[30:0]}, 32'h80000000);
		for (int i = 0; i < 6; i++) begin
			cfg(pm[i], ps[i], pp[i]);
			period(pe[i]);
		end
		// Out-of-range interval, reserved speed, control type
		cfg(8'h11, 2'h1, 2'h3);
		rd(ST_A, 32'h2, 32'h2, "bad cfg");
		polls = 0;
		cfg(8'h05, 2'h0, 2'h3);
		tick(8);
		cfg(8'h01, 2'h0, 2'h1);
		tick(8);
		chk("no poll rsvd", polls, 0);
		cfg(8'h01, 2'h2, 2'h0);
		tick(8);
		chk("no poll", polls, 0);
		// Bulk NAK run broken by a non-NAK answer
		cfg(8'h03, 2'h2, 2'h2);
		tos = 0;
		hs(1'b1);
		tick(3);
		hs(1'b0);
		hs(1'b1);
		tick(3);
		chk("early timeout", tos, 0);
		tick(1);
		chk("nak timeout", tos, 1);
		rd(ST_A, 32'h1, 32'h1, "timeout flag");
		apb(1'b1, ST_A, 32'h00000001);
		rd(ST_A, 32'h1, 32'h0, "timeout clear");
		for (int i = 0; i < 2; i++) begin
			cfg(8'(i), 2'h2, 2'h2);
			tos = 0;
			hs(1'b1);
			tick(12);
			chk("no timeout", tos, 0);
		end
		// Live receive count, read while the packet flag is set
		send(8'h05);
		rd(CFG_A, 32'h3fff, 32'h5, "rx count");
		chk("fifo flags", {30'h0, rx_push_ready, rx_pop_avail}, 32'h3);
		pop(8'h10);
		pop(8'h11);
		rd(CFG_A, 32'h3fff, 32'h3, "rx count live");
		apb(1'b1, RXC_A, 32'h0);
		for (int k = 2; k < 5; k++) pop(8'(8'h10 + k));
		// Auto-clear on a full packet only
		apb(1'b1, RXC_A, 32'h80000004);
		send(8'h04);
		for (int k = 0; k < 4; k++) pop(8'(8'h10 + k));
		@(posedge pclk);
		chk("auto clear", {31'h0, rx_ready_flag}, 32'h0);
		send(8'h03);
		for (int k = 0; k < 3; k++) pop(8'(8'h10 + k));
		@(posedge pclk);
		chk("short packet", {31'h0, rx_ready_flag}, 32'h1);
		give_verdict();
	end
endmodule // tb_top

`default_nettype wire
